// File: rtl/sdcad_decode.v
`timescale 1ns/1ps
`include "sdcad_map.vh"
// Contract
// - Row-open captures all twelve address lines as the row address.
// - Read/write take column from low nine lines; bit 10 selects auto-precharge.
// - Bank, row and column select exactly one 16-bit word location.
// - Precharge with address bit 10 high precharges every bank.
// - Mode-load takes new mode settings from the address lines.
// - Strobes are registered on rising edges and form the command code.
// - Low chip select and row strobe, others high: open row, bank active.
// - Row strobe and write select low: precharge, bank idle after completion.
// - Column strobe low, row strobe high: write if write select low, else read.
// - Chip select high masks all command inputs for that cycle.
// - Byte mask disables read drivers and blocks write storage for that byte.
// - Data lines sampled and driven in step with rising clock edges.
// - Precharge with bit 10 low precharges only the selected bank.
module sdcad_decode #(
  parameter ADDR_W = 12,
  parameter COL_W = 9,
  parameter DATA_W = 16
) (
  input wire clk,
  input wire sys_rst,
  input wire chip_sel_n,
  input wire row_strobe_n,
  input wire col_strobe_n,
  input wire write_sel_n,
  input wire [1:0] bank_sel,
  input wire [ADDR_W-1:0] addr_lines,
  input wire lower_byte_mask,
  input wire upper_byte_mask,
  input wire [DATA_W-1:0] data_lines_in,
  output reg [DATA_W-1:0] data_lines_out,
  output reg [1:0] data_lines_oe,
  output reg row_open_cmd,
  output reg precharge_cmd,
  output reg read_cmd,
  output reg write_cmd,
  output reg mode_cmd,
  output reg [1:0] cmd_bank,
  output reg [ADDR_W-1:0] row_addr,
  output reg [COL_W-1:0] col_addr,
  output reg auto_precharge,
  output reg precharge_all,
  output reg [ADDR_W-1:0] mode_opcode,
  output reg [3:0] bank_active,
  output reg [ADDR_W+COL_W+1:0] word_addr,
  output reg [DATA_W-1:0] write_data,
  output reg [1:0] write_byte_en,
  output reg write_valid
);

  // Input synchronisers, first stage
  reg cs_s1_r;
  reg ras_s1_r;
  reg cas_s1_r;
  reg we_s1_r;
  reg ldm_s1_r;
  reg udm_s1_r;
  reg [1:0] ba_s1_r;
  reg [ADDR_W-1:0] a_s1_r;
  reg [DATA_W-1:0] dq_s1_r;
  // Second stage, the only stage that logic reads
  reg cs_s2_r;
  reg ras_s2_r;
  reg cas_s2_r;
  reg we_s2_r;
  reg ldm_s2_r;
  reg udm_s2_r;
  reg [1:0] ba_s2_r;
  reg [ADDR_W-1:0] a_s2_r;
  reg [DATA_W-1:0] dq_s2_r;

  // Bank state and precharge timers
  reg [1:0] bank_st_r [0:3];
  reg [2:0] prech_cnt_r [0:3];
  reg [ADDR_W-1:0] open_row_r [0:3];
  reg [DATA_W-1:0] rd_word;
  integer i;

  // Bank state codes
  localparam BANK_IDLE = 2'h0;
  localparam BANK_ACTIVE = 2'h1;
  localparam BANK_PRECH = 2'h2;

  // One command code test, a deselected cycle never matches
  function cmd_is;
    input [2:0] code;
    input [2:0] want;
    input live;
    begin
      cmd_is = live && (code == want);
    end
  endfunction

  // Lane enables {upper, lower}: a high mask shuts its lane
  function [1:0] lane_en;
    input upper_mask;
    input lower_mask;
    begin
      lane_en = {~upper_mask, ~lower_mask};
    end
  endfunction

  // Bank number match for commands aimed at one bank
  function bank_is;
    input [1:0] b;
    input [1:0] sel;
    begin
      bank_is = (b == sel);
    end
  endfunction

  // Command code of the current cycle, chip select masks everything
  // Burst stop and refresh codes match nothing here and fall through as no-ops
  wire [2:0] cmd_code = {ras_s2_r, cas_s2_r, we_s2_r};
  wire cmd_live = ~cs_s2_r;
  wire dec_act = cmd_is(cmd_code, `SDCAD_CMD_ROW_OPEN, cmd_live);
  wire dec_pre = cmd_is(cmd_code, `SDCAD_CMD_PRECHARGE, cmd_live);
  wire dec_wr = cmd_is(cmd_code, `SDCAD_CMD_WRITE, cmd_live);
  wire dec_rd = cmd_is(cmd_code, `SDCAD_CMD_READ, cmd_live);
  wire dec_mode = cmd_is(cmd_code, `SDCAD_CMD_MODE, cmd_live);
  wire ap_bit = a_s2_r[`SDCAD_AP_BIT];
  // Lane enables of the current cycle, shared by write capture and read drivers
  wire [1:0] lane_w = lane_en(udm_s2_r, ldm_s2_r);

  // Precharge target test for one bank
  function hits_bank;
    input [1:0] b;
    input [1:0] sel;
    input all;
    begin
      hits_bank = all | bank_is(b, sel);
    end
  endfunction

  // Two-flop synchronisation of every pin input
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1_r <= 1'b1;
      ras_s1_r <= 1'b1;
      cas_s1_r <= 1'b1;
      we_s1_r <= 1'b1;
      ldm_s1_r <= 1'b1;
      udm_s1_r <= 1'b1;
      ba_s1_r <= 2'h0;
      a_s1_r <= {ADDR_W{1'b0}};
      dq_s1_r <= {DATA_W{1'b0}};
    end else begin
      cs_s1_r <= chip_sel_n;
      ras_s1_r <= row_strobe_n;
      cas_s1_r <= col_strobe_n;
      we_s1_r <= write_sel_n;
      ldm_s1_r <= lower_byte_mask;
      udm_s1_r <= upper_byte_mask;
      ba_s1_r <= bank_sel;
      a_s1_r <= addr_lines;
      dq_s1_r <= data_lines_in;
    end
  end

  // Second synchroniser stage, loads deselect so reset never looks like a command
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s2_r <= 1'b1;
      ras_s2_r <= 1'b1;
      cas_s2_r <= 1'b1;
      we_s2_r <= 1'b1;
      ldm_s2_r <= 1'b1;
      udm_s2_r <= 1'b1;
      ba_s2_r <= 2'h0;
      a_s2_r <= {ADDR_W{1'b0}};
      dq_s2_r <= {DATA_W{1'b0}};
    end else begin
      cs_s2_r <= cs_s1_r;
      ras_s2_r <= ras_s1_r;
      cas_s2_r <= cas_s1_r;
      we_s2_r <= we_s1_r;
      ldm_s2_r <= ldm_s1_r;
      udm_s2_r <= udm_s1_r;
      ba_s2_r <= ba_s1_r;
      a_s2_r <= a_s1_r;
      dq_s2_r <= dq_s1_r;
    end
  end

  // Read-back word: echo of the last written data stands in for the array
  always @* begin
    rd_word = write_data;
  end

  // Command decode outputs and address capture
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      row_open_cmd <= 1'b0;
      precharge_cmd <= 1'b0;
      read_cmd <= 1'b0;
      write_cmd <= 1'b0;
      mode_cmd <= 1'b0;
      cmd_bank <= 2'h0;
      row_addr <= {ADDR_W{1'b0}};
      col_addr <= {COL_W{1'b0}};
      auto_precharge <= 1'b0;
      precharge_all <= 1'b0;
      mode_opcode <= {ADDR_W{1'b0}};
      word_addr <= {(ADDR_W+COL_W+2){1'b0}};
    end else begin
      row_open_cmd <= dec_act;
      precharge_cmd <= dec_pre;
      read_cmd <= dec_rd;
      write_cmd <= dec_wr;
      mode_cmd <= dec_mode;
      if (cmd_live) begin
        cmd_bank <= ba_s2_r;
      end
      if (dec_act) begin
        row_addr <= a_s2_r;
      end
      if (dec_rd || dec_wr) begin
        col_addr <= a_s2_r[`SDCAD_COL_MSB:0];
        auto_precharge <= ap_bit;
        word_addr <= {ba_s2_r, open_row_r[ba_s2_r], a_s2_r[`SDCAD_COL_MSB:0]};
      end
      if (dec_pre) begin
        precharge_all <= ap_bit;
      end
      if (dec_mode) begin
        mode_opcode <= a_s2_r;
      end
    end
  end

  // Bank state machines with precharge countdown
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        bank_st_r[i] <= BANK_IDLE;
        prech_cnt_r[i] <= 3'h0;
        open_row_r[i] <= {ADDR_W{1'b0}};
      end
      bank_active <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        case (bank_st_r[i])
          BANK_IDLE: begin
            // Opening an already open bank is ignored, the first row stays
            if (dec_act && bank_is(ba_s2_r, i[1:0])) begin
              bank_st_r[i] <= BANK_ACTIVE;
              open_row_r[i] <= a_s2_r;
            end
          end
          BANK_ACTIVE: begin
            // Auto-precharge closes the row right after its column command
            if ((dec_pre && hits_bank(i[1:0], ba_s2_r, ap_bit)) ||
                ((dec_rd || dec_wr) && ap_bit && bank_is(ba_s2_r, i[1:0]))) begin
              bank_st_r[i] <= BANK_PRECH;
              prech_cnt_r[i] <= `SDCAD_PRECH_CYCLES;
            end
          end
          BANK_PRECH: begin
            // Countdown ends in idle, a new open is refused until then
            if (prech_cnt_r[i] <= 3'h1) begin
              bank_st_r[i] <= BANK_IDLE;
              prech_cnt_r[i] <= 3'h0;
            end else begin
              prech_cnt_r[i] <= prech_cnt_r[i] - 3'h1;
            end
          end
          default: begin
            bank_st_r[i] <= BANK_IDLE;
          end
        endcase
        // Visible state lags the internal state by one edge
        bank_active[i] <= (bank_st_r[i] == BANK_ACTIVE);
      end
    end
  end

  // Write capture: a masked byte keeps the old contents of the word
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      write_data <= {DATA_W{1'b0}};
      write_byte_en <= 2'h0;
      write_valid <= 1'b0;
    end else begin
      write_valid <= dec_wr;
      write_byte_en <= dec_wr ? lane_w : 2'h0;
      if (dec_wr && lane_w[0]) begin
        write_data[7:0] <= dq_s2_r[7:0];
      end
      if (dec_wr && lane_w[1]) begin
        write_data[DATA_W-1:8] <= dq_s2_r[DATA_W-1:8];
      end
    end
  end

  // Read drivers: enables stand for the read cycle only, one per unmasked lane
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_lines_out <= {DATA_W{1'b0}};
      data_lines_oe <= 2'h0;
    end else begin
      data_lines_out <= rd_word;
      data_lines_oe <= dec_rd ? lane_w : 2'h0;
    end
  end

endmodule // sdcad_decode

// File: rtl/sdcad_map.vh
`ifndef SDCAD_MAP_VH
`define SDCAD_MAP_VH
// Command codes {row_strobe_n, col_strobe_n, write_sel_n}
`define SDCAD_CMD_ROW_OPEN 3'h3
`define SDCAD_CMD_PRECHARGE 3'h2
`define SDCAD_CMD_WRITE 3'h4
`define SDCAD_CMD_READ 3'h5
`define SDCAD_CMD_MODE 3'h0
// Address field positions
`define SDCAD_AP_BIT 10
`define SDCAD_COL_MSB 8
// Bank states
`define SDCAD_BANK_IDLE 2'h0
`define SDCAD_BANK_ACTIVE 2'h1
`define SDCAD_BANK_PRECH 2'h2
// Precharge duration in cycles
`define SDCAD_PRECH_CYCLES 3'h2
`endif

// File: verif/sdcad_decode_properties.sv
`timescale 1ns/1ps
`include "sdcad_map.vh"
module sdcad_props #(
  parameter ADDR_W = 12,
  parameter COL_W = 9
) (
  input wire clk,
  input wire sys_rst,
  input wire chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n,
  input wire lower_byte_mask, upper_byte_mask,
  input wire [ADDR_W-1:0] addr_lines, row_addr, mode_opcode,
  input wire row_open_cmd, precharge_cmd, read_cmd, write_cmd, mode_cmd,
  input wire [COL_W-1:0] col_addr,
  input wire auto_precharge, precharge_all,
  input wire [3:0] bank_active,
  input wire [1:0] data_lines_oe, write_byte_en
);
  logic [ADDR_W+5:0] d1, d2, d3;
  // Pins delayed three edges so they line up with the registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      {d1, d2, d3} <= '1;
    else
      {d1, d2, d3} <= {chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n, upper_byte_mask,
        lower_byte_mask, addr_lines, d1, d2};
  end
  // Fields of the delayed command
  wire sel = !d3[ADDR_W+5];
  wire [2:0] cd = d3[ADDR_W+4:ADDR_W+2];
  wire [1:0] en = ~d3[ADDR_W+1:ADDR_W];
  wire [ADDR_W-1:0] a3 = d3[ADDR_W-1:0];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_all_prech; precharge_cmd && precharge_all; endsequence
  sequence s_banks_idle; bank_active == 4'h0; endsequence
  a_open_decode: assert property (row_open_cmd == (sel && cd == `SDCAD_CMD_ROW_OPEN))
    else $error("row open pulse wrong");
  a_prech_decode: assert property (precharge_cmd == (sel && cd == `SDCAD_CMD_PRECHARGE))
    else $error("precharge pulse wrong");
  a_col_decode: assert property ({read_cmd, write_cmd} ==
    {sel && cd == `SDCAD_CMD_READ, sel && cd == `SDCAD_CMD_WRITE}) else $error("column pulse wrong");
  a_row_capture: assert property (row_open_cmd |-> row_addr == a3)
    else $error("row address wrong");
  a_col_capture: assert property ((read_cmd || write_cmd) |-> col_addr == a3[COL_W-1:0]
    && auto_precharge == a3[`SDCAD_AP_BIT]) else $error("column fields wrong");
  a_prech_scope: assert property (precharge_cmd |-> precharge_all == a3[`SDCAD_AP_BIT])
    else $error("precharge scope wrong");
  a_all_idle: assert property (s_all_prech |-> ##[1:6] s_banks_idle)
    else $error("banks not idle after precharge all");
  a_mode_capture: assert property (mode_cmd |-> mode_opcode == a3)
    else $error("mode code wrong");
  a_mask_lanes: assert property (data_lines_oe == (read_cmd ? en : 2'h0)
    && (!write_cmd || write_byte_en == en)) else $error("byte lanes wrong");
endmodule // sdcad_props
bind sdcad_decode sdcad_props #(.ADDR_W(ADDR_W), .COL_W(COL_W)) props_u (.*);

// File: verif/sdcad_ctl_model.sv
`timescale 1ns/1ps
`include "sdcad_map.vh"
// Controller side: one command per clock, pins moved at the falling edge
module sdcad_ctl_model (
  input wire clk,
  output logic chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n,
  output logic lower_byte_mask, upper_byte_mask,
  output logic [1:0] bank_sel,
  output logic [11:0] addr_lines,
  output logic [15:0] data_lines_in
);
  // Deselected from time zero so reset sees no command
  initial {chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n, bank_sel, addr_lines} = '1;
  initial {lower_byte_mask, upper_byte_mask, data_lines_in} = '0;
  // Released data lines toggle instead of holding the last word
  task issue(input logic cs, input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
    input logic [1:0] m, input logic [15:0] d);
    @(negedge clk);
    {chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n} <= {cs, c};
    {bank_sel, addr_lines} <= {b, a};
    {upper_byte_mask, lower_byte_mask} <= m;
    data_lines_in <= (!cs && c == `SDCAD_CMD_WRITE) ? d : ~data_lines_in;
  endtask
endmodule // sdcad_ctl_model

// File: verif/tb_sdcad_decode.sv
`timescale 1ns/1ps
`include "sdcad_map.vh"
module tb_sdcad_decode;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  integer seed = 30285;
  integer num_errors = 0;
  integer check_count = 0;
  integer i;
  logic [11:0] open_row [4];
  logic [63:0] exp_q [$];
  logic [63:0] g;
  logic [2:0] k;
  logic [15:0] mem_w = 16'h0;
  wire chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n, lower_byte_mask, upper_byte_mask;
  wire [1:0] bank_sel, data_lines_oe, cmd_bank, write_byte_en;
  wire [11:0] addr_lines, row_addr, mode_opcode;
  wire [15:0] data_lines_in, data_lines_out, write_data;
  wire [8:0] col_addr;
  wire [3:0] bank_active;
  wire [22:0] word_addr;
  wire row_open_cmd, precharge_cmd, read_cmd, write_cmd, mode_cmd, auto_precharge;
  wire precharge_all, write_valid;
  always #4 clk = ~clk;
  sdcad_ctl_model ctl_u (.*);
  sdcad_decode dut_u (.*);
  task check_cmd(input logic [63:0] e, input logic [63:0] v);
    check_count++;
    if (e !== v) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, v);
    end
  endtask
  task check_bank(input logic [3:0] e);
    integer j;
    for (j = 0; j < 12 && bank_active !== e; j++) @(negedge clk);
    check_count++;
    if (bank_active !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, bank_active);
    end
  endtask
  task cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
    input logic [15:0] d);
    if (c == `SDCAD_CMD_ROW_OPEN) open_row[b] = a;
    if (c == `SDCAD_CMD_WRITE)
      mem_w = (mem_w & {{8{m[1]}}, {8{m[0]}}}) | (d & ~{{8{m[1]}}, {8{m[0]}}});
    if (c == `SDCAD_CMD_PRECHARGE)
      exp_q.push_back({c, 58'h0, b, a[10]});
    else if (c == `SDCAD_CMD_ROW_OPEN || c == `SDCAD_CMD_MODE)
      exp_q.push_back({c, 47'h0, b, a});
    else
      exp_q.push_back({c, 7'h0, b, ~c[0], ~m, mem_w, a[10], a[8:0], b, open_row[b], a[8:0]});
    ctl_u.issue(1'b0, c, b, a, m, d);
  endtask
  task idle(input integer n);
    repeat (n) ctl_u.issue(1'b1, 3'($random(seed)), 2'($random(seed)), 12'($random(seed)),
      2'h0, 16'h0);
  endtask
  task give_verdict;
    if (exp_q.size() != 0) num_errors++;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Rebuilds the note of each command pulse and matches it with the oldest one queued
  always @(negedge clk) begin
    if (row_open_cmd || precharge_cmd || read_cmd || write_cmd || mode_cmd) begin
      k = row_open_cmd ? `SDCAD_CMD_ROW_OPEN : precharge_cmd ? `SDCAD_CMD_PRECHARGE
        : write_cmd ? `SDCAD_CMD_WRITE : read_cmd ? `SDCAD_CMD_READ : `SDCAD_CMD_MODE;
      if (precharge_cmd)
        g = {k, 58'h0, cmd_bank, precharge_all};
      else if (row_open_cmd || mode_cmd)
        g = {k, 47'h0, cmd_bank, row_open_cmd ? row_addr : mode_opcode};
      else
        g = {k, 7'h0, cmd_bank, write_valid, write_cmd ? write_byte_en : data_lines_oe,
          write_cmd ? write_data : data_lines_out, auto_precharge, col_addr, word_addr};
      check_cmd(exp_q.size() > 0 ? exp_q.pop_front() : 64'h0, g);
    end
  end
  // Reset, mode load, row opens, masked column traffic, deselects and precharges
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    cmd(`SDCAD_CMD_MODE, 2'h0, 12'($random(seed)), 2'h0, 16'h0);
    for (i = 0; i < 4; i++) cmd(`SDCAD_CMD_ROW_OPEN, 2'(i), 12'($random(seed)), 2'h0, 16'h0);
    idle(1);
    check_bank(4'hF);
    for (i = 0; i < 16; i++)
      cmd(i[0] ? `SDCAD_CMD_READ : `SDCAD_CMD_WRITE, 2'($random(seed)),
        12'($random(seed)) & 12'hBFF, 2'(i >> 1), 16'($random(seed)));
    idle(3);
    cmd(`SDCAD_CMD_PRECHARGE, 2'h2, 12'h3FF, 2'h0, 16'h0);
    idle(1);
    check_bank(4'hB);
    cmd(`SDCAD_CMD_WRITE, 2'h0, 12'h455, 2'h1, 16'hA5C3);
    idle(1);
    check_bank(4'hA);
    cmd(`SDCAD_CMD_PRECHARGE, 2'h1, 12'h400, 2'h0, 16'h0);
    idle(1);
    check_bank(4'h0);
    idle(6);
    give_verdict();
  end
endmodule // tb_sdcad_decode
